// ---- adc_conv_model.sv ----
// Purpose: Behavioural converter at the far side of the serial port
// Assumes: Host makes the serial clock; select is active low
// Notes:   Released data line toggles so stale bits never look valid
`timescale 1ns/1ps

module adc_conv_model #(
    parameter int PWRUP_DLY_NS = 1000
) (
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [11:0] sample_in,
    output logic             sdata,
    output logic             powered
);
    logic [15:0] word    = 16'h0000;
    logic        asleep  = 1'b0;
    logic        junk    = 1'b0;
    int          falls   = 0;
    int          bit_idx = 15;

    initial powered = 1'b1;
    always #7 junk = ~junk;
    // Sample taken at select fall, four leading zeros then result
    always @(negedge cs_n) begin
        word    = {4'h0, sample_in};
        bit_idx = 15;
        falls   = 0;
    end
    always @(negedge sclk) begin
        if (!cs_n) begin
            falls = falls + 1;
            if (asleep && falls == 10) begin
                asleep = 1'b0;
                powered <= #(PWRUP_DLY_NS) 1'b1;
            end
        end
    end
    // Next bit after each rise, steady across the host's sampling fall
    always @(posedge sclk) begin
        if (!cs_n && bit_idx > 0) begin
            bit_idx = bit_idx - 1;
        end
    end
    // Release before fall two is a glitch and is ignored
    always @(posedge cs_n) begin
        if (!asleep && falls >= 2 && falls < 10) begin
            asleep  = 1'b1;
            powered = 1'b0;
        end
    end
    assign sdata = (cs_n || !powered) ? junk : word[bit_idx[3:0]];
endmodule : adc_conv_model

// ---- adc_host_pkg.sv ----
// Purpose: Shared constants for the converter serial host controller
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register bus
// Notes:   Offsets are byte addresses of aligned words
package adc_host_pkg;

    // Register offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  DIV_OFS         = 8'h04;
    localparam logic [7:0]  PERIOD_OFS      = 8'h08;
    localparam logic [7:0]  STATUS_OFS      = 8'h0c;
    localparam logic [7:0]  DATA_OFS        = 8'h10;

    // Control fields
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam int unsigned CTRL_MODE_LSB   = 1;
    localparam int unsigned CTRL_CONT_BIT   = 3;

    // Status fields
    localparam int unsigned STAT_BUSY_BIT   = 0;
    localparam int unsigned STAT_VALID_BIT  = 1;
    localparam int unsigned STAT_OVR_BIT    = 2;
    localparam int unsigned STAT_AWAKE_BIT  = 3;

    // Reset values and minimum divider
    localparam logic [15:0] DIV_RST         = 16'h0004;
    localparam logic [15:0] PERIOD_RST      = 16'h0014;
    localparam logic [15:0] DIV_MIN         = 16'h0002;

    // Frame kinds
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_SLEEP  = 2'h1,
        MODE_WAKE   = 2'h2
    } mode_e;

    // Clocks per frame, word and data widths
    localparam logic [4:0]  NORMAL_CLKS     = 5'h10;
    localparam logic [4:0]  SLEEP_CLKS      = 5'h08;
    localparam int unsigned WORD_W          = 16;
    localparam int unsigned DATA_W          = 12;

    // Timing
    localparam int unsigned HCLK_PERIOD_NS  = 10;
    localparam int unsigned PWRUP_NS        = 1000;
    localparam int unsigned PWRUP_CYC       = (PWRUP_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
    localparam logic [3:0]  QUIET_PERIODS   = 4'h1;

endpackage : adc_host_pkg

// ---- adc_serial_host.sv ----
// Purpose: Host controller framing a 12-bit converter serial port
// Assumes: Single hclk domain; serial clock made here by a divider
// Notes:   Zero-wait AHB-Lite slave holds control, status and data
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps

module adc_serial_host
    import adc_host_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        adc_sdata,
    output logic             adc_sclk,
    output logic             adc_cs_n,
    output logic             host_tx_frame
);

    typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_TRAIL, ST_QUIET} state_e;

    state_e              state_reg;
    logic                acc_wr_reg;
    logic [7:0]          acc_addr_reg;
    logic [1:0]          mode_reg;
    logic                cont_reg;
    logic                pend_reg;
    logic [15:0]         div_reg;
    logic [15:0]         period_reg;
    logic [15:0]         half_cnt_reg;
    logic                phase_reg;
    logic [15:0]         per_cnt_reg;
    logic [1:0]          fmode_reg;
    logic [4:0]          falls_reg;
    logic [3:0]          quiet_reg;
    logic [WORD_W-1:0]   shift_reg;
    logic [DATA_W-1:0]   data_reg;
    logic                valid_reg;
    logic                ovr_reg;
    logic                awake_reg;
    logic [15:0]         pwr_cnt_reg;
    logic                pwr_wait_reg;
    logic                sd_s1_reg;
    logic                sd_s2_reg;

    logic                accept;
    logic                do_write;
    logic                start_wr;
    logic                data_rd;
    logic [15:0]         div_eff;
    logic                half_tick;
    logic                period_tick;
    logic [15:0]         per_next;
    logic                cont_due;
    logic                frame_go;
    logic [4:0]          frame_clks;
    logic                frame_done;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    // Bus side
    assign accept   = hsel && htrans[1] && hready;
    assign do_write = acc_wr_reg;
    assign start_wr = do_write && hit(acc_addr_reg, CTRL_OFS) && hwdata[CTRL_START_BIT];
    assign data_rd  = accept && !hwrite && hit(haddr[7:0], DATA_OFS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_wr_reg   <= 1'b0;
            acc_addr_reg <= 8'h00;
        end else if (ce) begin
            acc_wr_reg   <= accept && hwrite;
            acc_addr_reg <= haddr[7:0];
        end
    end

    // Always ready and OKAY: every register answers in one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg   <= MODE_NORMAL;
            cont_reg   <= 1'b0;
            div_reg    <= DIV_RST;
            period_reg <= PERIOD_RST;
        end else if (ce && do_write) begin
            if (hit(acc_addr_reg, CTRL_OFS)) begin
                mode_reg <= hwdata[CTRL_MODE_LSB +: 2];
                cont_reg <= hwdata[CTRL_CONT_BIT];
            end else if (hit(acc_addr_reg, DIV_OFS)) begin
                div_reg <= hwdata[15:0];
            end else if (hit(acc_addr_reg, PERIOD_OFS)) begin
                period_reg <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && accept && !hwrite) begin
            if (hit(haddr[7:0], CTRL_OFS)) begin
                hrdata <= {28'h0, cont_reg, mode_reg, 1'b0};
            end else if (hit(haddr[7:0], DIV_OFS)) begin
                hrdata <= {16'h0, div_reg};
            end else if (hit(haddr[7:0], PERIOD_OFS)) begin
                hrdata <= {16'h0, period_reg};
            end else if (hit(haddr[7:0], STATUS_OFS)) begin
                hrdata <= {28'h0, awake_reg, ovr_reg, valid_reg, state_reg != ST_IDLE};
            end else if (hit(haddr[7:0], DATA_OFS)) begin
                hrdata <= {20'h0, data_reg};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Serial clock timebase; runs free so frame starts land on boundaries
    assign div_eff     = (div_reg < DIV_MIN) ? DIV_MIN : div_reg;
    assign half_tick   = (half_cnt_reg == div_eff - 16'h0001);
    assign period_tick = half_tick && phase_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_cnt_reg <= 16'h0000;
            phase_reg    <= 1'b0;
        end else if (ce) begin
            if (half_tick || half_cnt_reg > div_eff) begin
                half_cnt_reg <= 16'h0000;
                phase_reg    <= !phase_reg;
            end else begin
                half_cnt_reg <= half_cnt_reg + 16'h0001;
            end
        end
    end

    // Frame scheduling in whole serial periods
    assign per_next   = (per_cnt_reg == 16'hffff) ? per_cnt_reg : per_cnt_reg + 16'h0001;
    assign cont_due   = cont_reg && (per_next >= period_reg);
    assign frame_go   = period_tick && (state_reg == ST_IDLE) && (pend_reg || cont_due);
    assign frame_clks = (fmode_reg == MODE_SLEEP) ? SLEEP_CLKS : NORMAL_CLKS;
    assign frame_done = half_tick && (state_reg == ST_TRAIL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_cnt_reg <= 16'h0000;
        end else if (ce) begin
            if (frame_go) begin
                per_cnt_reg <= 16'h0000;
            end else if (period_tick) begin
                per_cnt_reg <= per_next;
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
        end else if (ce) begin
            if (start_wr) begin
                pend_reg <= 1'b1;
            end else if (frame_go) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // Link sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            adc_sclk  <= 1'b1;
            adc_cs_n  <= 1'b1;
            falls_reg <= 5'h00;
            quiet_reg <= 4'h0;
            fmode_reg <= MODE_NORMAL;
        end else if (ce) begin
            case (state_reg)
                ST_IDLE: begin
                    adc_sclk <= 1'b1;
                    if (frame_go) begin
                        adc_cs_n  <= 1'b0;
                        falls_reg <= 5'h00;
                        fmode_reg <= mode_reg;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (half_tick) begin
                        if (adc_sclk) begin
                            adc_sclk  <= 1'b0;
                            falls_reg <= falls_reg + 5'h01;
                        end else begin
                            adc_sclk <= 1'b1;
                            if (falls_reg == frame_clks) begin
                                state_reg <= ST_TRAIL;
                            end
                        end
                    end
                end
                ST_TRAIL: begin
                    if (half_tick) begin
                        adc_cs_n  <= 1'b1;
                        quiet_reg <= 4'h0;
                        state_reg <= ST_QUIET;
                    end
                end
                ST_QUIET: begin
                    if (period_tick) begin
                        quiet_reg <= quiet_reg + 4'h1;
                        if (quiet_reg + 4'h1 >= QUIET_PERIODS) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // One serial period of frame sync from the select fall
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_tx_frame <= 1'b0;
        end else if (ce) begin
            if (frame_go) begin
                host_tx_frame <= 1'b1;
            end else if (period_tick) begin
                host_tx_frame <= 1'b0;
            end
        end
    end

    // Data pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_s1_reg <= 1'b0;
            sd_s2_reg <= 1'b0;
        end else if (ce) begin
            sd_s1_reg <= adc_sdata;
            sd_s2_reg <= sd_s1_reg;
        end
    end

    // Sampled at each falling edge, only while select is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= '0;
        end else if (ce) begin
            if (frame_go) begin
                shift_reg <= '0;
            end else if (state_reg == ST_SHIFT && half_tick && adc_sclk) begin
                shift_reg <= {shift_reg[WORD_W-2:0], sd_s2_reg};
            end
        end
    end

    // Result capture; wake dummy words are discarded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_reg  <= '0;
            valid_reg <= 1'b0;
            ovr_reg   <= 1'b0;
        end else if (ce) begin
            if (frame_done && fmode_reg == MODE_NORMAL) begin
                data_reg  <= shift_reg[DATA_W-1:0];
                valid_reg <= 1'b1;
                ovr_reg   <= ovr_reg || valid_reg;
            end else if (data_rd) begin
                valid_reg <= 1'b0;
                ovr_reg   <= 1'b0;
            end
        end
    end

    // Powered flag follows the frames sent: a sleep frame clears it, a wake frame sets it a power-up time after its end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            awake_reg    <= 1'b0;
            pwr_wait_reg <= 1'b0;
            pwr_cnt_reg  <= 16'h0000;
        end else if (ce) begin
            if (frame_done && fmode_reg == MODE_SLEEP) begin
                awake_reg    <= 1'b0;
                pwr_wait_reg <= 1'b0;
            end else if (frame_done && fmode_reg == MODE_WAKE) begin
                pwr_wait_reg <= 1'b1;
                pwr_cnt_reg  <= 16'h0000;
            end else if (pwr_wait_reg) begin
                if (pwr_cnt_reg == 16'(PWRUP_CYC - 1)) begin
                    awake_reg    <= 1'b1;
                    pwr_wait_reg <= 1'b0;
                end else begin
                    pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
                end
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence cs_release_s;
        $rose(adc_cs_n);
    endsequence

    sequence quiet_hold_s;
        !$fell(adc_cs_n) [*3];
    endsequence

    idle_clk_high_a: assert property (adc_cs_n |-> adc_sclk)
        else $error("serial clock low outside a frame");

    normal_len_a: assert property (cs_release_s and (fmode_reg != MODE_SLEEP)
                                   |-> falls_reg == NORMAL_CLKS)
        else $error("normal frame without sixteen clocks");

    sleep_len_a: assert property (cs_release_s and (fmode_reg == MODE_SLEEP)
                                  |-> falls_reg == SLEEP_CLKS)
        else $error("power-down burst without eight clocks");

    cs_steady_a: assert property (state_reg == ST_SHIFT |-> !adc_cs_n)
        else $error("select rose during shifting");

    frame_sync_a: assert property ($fell(adc_cs_n) |-> host_tx_frame && $past(period_tick))
        else $error("frame sync or boundary missing at select fall");

    quiet_gap_a: assert property (cs_release_s |=> quiet_hold_s)
        else $error("select fell again too soon");

    sclk_half_a: assert property (ce && $changed(adc_sclk) |=> $stable(adc_sclk))
        else $error("serial clock half period under two cycles");

    valid_cause_a: assert property ($rose(valid_reg) |->
                                    $past(frame_done) && $past(fmode_reg) == MODE_NORMAL)
        else $error("data valid without a normal frame end");

    wake_ready_a: assert property ($rose(awake_reg) |->
                                   $past(pwr_cnt_reg) == 16'(PWRUP_CYC - 1))
        else $error("awake flag before power-up time");

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");

endmodule : adc_serial_host

// ---- tb_adc_serial_host.sv ----
// Purpose: Self-checking bench for the converter serial host
// Assumes: Zero-wait bus slave; divider kept at 4 or more
// Notes:   Frame shape is measured at hclk edges by a monitor
`timescale 1ns/1ps

module tb_adc_serial_host;
    import adc_host_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        adc_sdata, adc_sclk, adc_cs_n, host_tx_frame, powered;
    logic        cs_q = 1'b1;
    logic        sclk_q = 1'b1;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [11:0] sample;
    int          fails, cmp_count, seed, cyc, nf, ftx, nfr, t_rise, div;
    int          falls_q[$], txw_q[$], start_q[$], quiet_q[$], exp_q[$];

    adc_serial_host dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .adc_sdata(adc_sdata), .adc_sclk(adc_sclk), .adc_cs_n(adc_cs_n),
        .host_tx_frame(host_tx_frame));
    adc_conv_model model (.sclk(adc_sclk), .cs_n(adc_cs_n), .sample_in(sample),
        .sdata(adc_sdata), .powered(powered));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t register got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_link(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED %0t link got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_link

    // Address phase held until hready, then data phase until hready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk_reg({31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk_reg(rd, e);
    endtask : rdr

    task automatic wait_frames(input int n);
        int tgt;
        tgt = nfr + n;
        for (int i = 0; i < 20000 && nfr < tgt; i++) @(posedge hclk);
        chk_link(nfr, tgt);
        // Past the quiet state even at the slowest divider, so busy reads 0
        repeat (16) @(posedge hclk);
    endtask : wait_frames

    task automatic frame(input mode_e m);
        if (m == MODE_NORMAL) exp_q.push_back(int'(sample));
        ahb(1'b1, CTRL_OFS, {28'h0, 1'b0, m, 1'b1});
        wait_frames(1);
    endtask : frame

    // Power-up counted from the end of the dummy frame
    task automatic wake_up;
        frame(MODE_WAKE);
        chk_link(falls_q[$], 16);
        rdr(STATUS_OFS, 32'h0);
        repeat (110) @(posedge hclk);
        rdr(STATUS_OFS, 32'h8);
        chk_link(int'(powered), 1);
    endtask : wake_up

    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cs_q && adc_cs_n === 1'b0) begin
            if (t_rise > 0) quiet_q.push_back(cyc - t_rise);
            start_q.push_back(cyc);
            nf  = 0;
            ftx = 0;
        end
        if (adc_cs_n === 1'b0) begin
            if (sclk_q && adc_sclk === 1'b0) nf = nf + 1;
            if (host_tx_frame === 1'b1) ftx = ftx + 1;
        end
        if (!cs_q && adc_cs_n === 1'b1) begin
            falls_q.push_back(nf);
            txw_q.push_back(ftx);
            t_rise = cyc;
            nfr    = nfr + 1;
        end
        if (hresetn === 1'b1 && adc_cs_n === 1'b1 && adc_sclk !== 1'b1) chk_link(0, 1);
        cs_q   = adc_cs_n;
        sclk_q = adc_sclk;
    end

    // Whole run is a few thousand cycles; this is ample headroom
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        seed   = 43496;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, sample} = '0;
        hsize  = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_reg({29'h0, adc_sclk, adc_cs_n, host_tx_frame}, 32'h6);
        rdr(DIV_OFS, 32'h4);
        rdr(PERIOD_OFS, 32'h14);
        rdr(DATA_OFS, 32'h0);
        ahb(1'b1, 8'h14, 32'hffffffff);
        rdr(8'h14, 32'h0);
        wake_up();
        for (int k = 0; k < 6; k++) begin
            div    = 4 + ($random(seed) & 3);
            sample = 12'($random(seed));
            ahb(1'b1, DIV_OFS, 32'(div));
            rdr(DIV_OFS, 32'(div));
            frame(MODE_NORMAL);
            chk_link(falls_q[$], 16);
            chk_link(txw_q[$], 2 * div);
            rdr(STATUS_OFS, 32'ha);
            rdr(DATA_OFS, 32'(exp_q[$]));
            exp_q.delete();
        end
        rdr(STATUS_OFS, 32'h8);
        sample = 12'($random(seed));
        ahb(1'b1, CTRL_OFS, 32'h1);
        // Second start only once the first frame runs; two early starts merge
        for (int i = 0; i < 2000 && adc_cs_n !== 1'b0; i++) @(posedge hclk);
        ahb(1'b1, CTRL_OFS, 32'h1);
        wait_frames(2);
        chk_link(int'(quiet_q[$] >= 2 * div * int'(QUIET_PERIODS)), 1);
        rdr(STATUS_OFS, 32'he);
        rdr(DATA_OFS, {20'h0, sample});
        frame(MODE_SLEEP);
        chk_link(falls_q[$], 8);
        chk_link(int'(powered), 0);
        rdr(STATUS_OFS, 32'h0);
        wake_up();
        sample = 12'($random(seed));
        ahb(1'b1, DIV_OFS, 32'h4);
        ahb(1'b1, PERIOD_OFS, 32'h14);
        ahb(1'b1, CTRL_OFS, 32'h9);
        wait_frames(4);
        ahb(1'b1, CTRL_OFS, 32'h0);
        chk_link(start_q[$] - start_q[$ - 1], 160);
        chk_link(start_q[$ - 1] - start_q[$ - 2], 160);
        repeat (400) @(posedge hclk);
        rdr(DATA_OFS, {20'h0, sample});
        report_and_stop();
    end
endmodule : tb_adc_serial_host
